// ### verilog/dma_pkg.sv
// Purpose: shared constants and types for the single-channel transfer/search engine
// Assumes: 8-bit data, 16-bit addresses and block length
// Notes:   operation, transfer direction and address modes are encoded here
package dma_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int LEN_W  = 16;
   localparam int FIFO_DEPTH = 16;

   localparam logic [ADDR_W-1:0] ADDR_RST  = 16'h0000;
   localparam logic [LEN_W-1:0]  COUNT_RST = 16'h0000;
   localparam logic [LEN_W-1:0]  COUNT_ONE = 16'h0001;
   localparam logic [DATA_W-1:0] DATA_RST  = 8'h00;

   // per-port address mode
   typedef enum logic [1:0] {
      ADDR_INC   = 2'h0,
      ADDR_DEC   = 2'h1,
      ADDR_FIXED = 2'h2
   } addr_mode_t;

   // operation class
   typedef enum logic [1:0] {
      OP_TRANSFER = 2'h0,
      OP_SEARCH   = 2'h1,
      OP_BOTH     = 2'h2
   } op_class_t;

   // transfer direction
   typedef enum logic [1:0] {
      DIR_MEM_MEM = 2'h0,
      DIR_MEM_IO  = 2'h1,
      DIR_IO_MEM  = 2'h2
   } dir_t;

endpackage

// ### verilog/byte_fifo.sv
// Purpose: synchronous flip-flop FIFO between the read and write phases
// Assumes: single clock, synchronous active-high reset
// Notes:   full and empty come straight from the occupancy count
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             sys_rst_in,
   // fill side
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // drain side
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out,
   // flush
   input  wire logic             flush_in
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q;
   logic [PTR_W-1:0] rd_ptr_q;
   logic [CNT_W-1:0] count_q;
   logic             push;
   logic             pop;

   assign in_ready_out  = (count_q != CNT_W'(DEPTH));
   assign out_valid_out = (count_q != '0);
   assign out_data_out  = mem_q[rd_ptr_q];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in || flush_in) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end
endmodule

// ### verilog/dma_channel.sv
// Purpose: single-channel block transfer and byte-search engine with bus mastering
// Assumes: host writes start addresses and length before enable; one clock domain
// Notes:   sequential mode buffers read bytes in a FIFO before the write phase
//
// Functional notes
// - Moves blocks memory to memory, memory to I/O, or I/O to memory in one channel.
// - Searches bytes for a pattern, alone without writes or alongside a transfer.
// - Each moved byte steps the port address up, down or not at all per that port's address mode.
// - A byte counter starts at zero and counts up to the programmed block length.
// - Data moves only while the channel is enabled and the peripheral ready is active.
// - After the whole block the engine notifies the host and releases the bus in the same cycle.
// - Sequential transfers drive source addresses for a run of up to 16 reads, then destination addresses; flyby drives only the memory-side address.
// - One channel holds address and byte counting, bus control and sequencing.
// - Each byte entering the data register is compared to a match byte under a mask, except in a plain transfer (OP_TRANSFER).
// - Sequential transfer reads a byte into the engine, then writes it in a later cycle.
// - Simultaneous transfer asserts read and write strobes together in one cycle.
// - Each port has its own address mode: up, down or fixed.
// - A sixteen-bit length count expresses blocks up to 64K-1 bytes.
`timescale 1ns/1ps
module dma_channel
   import dma_pkg::*;
#(
   parameter int FIFO_W = DATA_W,
   parameter int FIFO_D = FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                   clk_in,
   input  wire logic                   sys_rst_in,
   // programming (static while enabled)
   input  wire logic                   enable_in,
   input  wire dma_pkg::dir_t          dir_in,
   input  wire dma_pkg::op_class_t     op_in,
   input  wire logic                   flyby_in,
   input  wire logic [dma_pkg::ADDR_W-1:0] src_addr_in,
   input  wire logic [dma_pkg::ADDR_W-1:0] dst_addr_in,
   input  wire dma_pkg::addr_mode_t    src_mode_in,
   input  wire dma_pkg::addr_mode_t    dst_mode_in,
   input  wire logic [dma_pkg::LEN_W-1:0]  block_len_in,
   input  wire logic [dma_pkg::DATA_W-1:0] match_byte_in,
   input  wire logic [dma_pkg::DATA_W-1:0] match_mask_in,
   // peripheral and host handshake pins
   input  wire logic                   periph_ready_in,
   input  wire logic                   bus_grant_in,
   output logic                        bus_req_out,
   output logic                        done_out,
   output logic                        match_out,
   output logic                        busy_out,
   output logic [dma_pkg::LEN_W-1:0]   count_out,
   // system bus (address/control driven while granted)
   output logic [dma_pkg::ADDR_W-1:0]  addr_out,
   output logic                        addr_oe_out,
   output logic                        mem_rd_out,
   output logic                        mem_wr_out,
   output logic                        io_rd_out,
   output logic                        io_wr_out,
   input  wire logic [dma_pkg::DATA_W-1:0] data_in,
   output logic [dma_pkg::DATA_W-1:0]  data_out,
   output logic                        data_oe_out
);
   import dma_pkg::*;

   // ------------------------------------------------------------------
   // state and storage
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_REQ,
      ST_READ,
      ST_WRITE,
      ST_FLY,
      ST_DONE
   } state_t;

   state_t            state_q;
   state_t            state_d;
   logic [ADDR_W-1:0] src_q;
   logic [ADDR_W-1:0] dst_q;
   logic [LEN_W-1:0]  rd_cnt_q;
   logic [LEN_W-1:0]  wr_cnt_q;
   logic [DATA_W-1:0] data_reg_q;
   logic              match_q;
   logic              load_q;
   logic              done_q;
   logic              ready_s1_q;
   logic              ready_s2_q;
   logic              grant_s1_q;
   logic              grant_s2_q;

   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic [DATA_W-1:0] fifo_out_data;
   logic              fifo_push;
   logic              fifo_pop;
   logic              fifo_flush;
   logic              do_write;
   logic              src_is_mem;
   logic              dst_is_mem;
   logic              rd_left;
   logic              wr_left;
   logic              go;

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         ready_s1_q <= 1'b0;
         ready_s2_q <= 1'b0;
         grant_s1_q <= 1'b0;
         grant_s2_q <= 1'b0;
      end else begin
         ready_s1_q <= periph_ready_in;
         ready_s2_q <= ready_s1_q;
         grant_s1_q <= bus_grant_in;
         grant_s2_q <= grant_s1_q;
      end
   end

   // ------------------------------------------------------------------
   // decode
   // ------------------------------------------------------------------
   assign src_is_mem = (dir_in != DIR_IO_MEM);
   assign dst_is_mem = (dir_in != DIR_MEM_IO);
   assign do_write   = (op_in != OP_SEARCH);
   // a zero length never starts; limits blocks to 64K-1 with a 16-bit count
   assign rd_left    = (rd_cnt_q != block_len_in);
   assign wr_left    = (wr_cnt_q != block_len_in);
   assign go         = enable_in && ready_s2_q;
   assign fifo_push  = (state_q == ST_READ) && do_write && go && rd_left && fifo_in_ready;
   assign fifo_pop   = (state_q == ST_WRITE) && go && fifo_out_valid;
   assign fifo_flush = (state_q == ST_IDLE);

   // ------------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (enable_in && block_len_in != COUNT_RST) begin
               state_d = ST_REQ;
            end
         end
         ST_REQ: begin
            if (grant_s2_q && go) begin
               state_d = (flyby_in && dir_in != DIR_MEM_MEM && do_write) ? ST_FLY : ST_READ;
            end
         end
         ST_READ: begin
            // move to the write phase when the buffer fills or reading ends
            if (!rd_left || (do_write && !fifo_in_ready)) begin
               state_d = do_write ? ST_WRITE : ST_DONE;
            end
         end
         ST_WRITE: begin
            if (!fifo_out_valid) begin
               state_d = (wr_left) ? ST_READ : ST_DONE;
            end
         end
         ST_FLY: begin
            if (!rd_left) begin
               state_d = ST_DONE;
            end
         end
         ST_DONE: begin
            if (!enable_in) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ------------------------------------------------------------------
   // address and byte counters
   // ------------------------------------------------------------------
   function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a,
                                               input addr_mode_t m);
      case (m)
         ADDR_INC: step = a + ADDR_W'(1);
         ADDR_DEC: step = a - ADDR_W'(1);
         default:  step = a;
      endcase
   endfunction

   logic rd_beat;
   logic fly_beat;
   assign rd_beat  = (state_q == ST_READ) && go && rd_left && (!do_write || fifo_in_ready);
   assign fly_beat = (state_q == ST_FLY) && go && rd_left;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         src_q    <= ADDR_RST;
         dst_q    <= ADDR_RST;
         rd_cnt_q <= COUNT_RST;
         wr_cnt_q <= COUNT_RST;
      end else if (state_q == ST_IDLE) begin
         src_q    <= src_addr_in;
         dst_q    <= dst_addr_in;
         rd_cnt_q <= COUNT_RST;
         wr_cnt_q <= COUNT_RST;
      end else begin
         if (rd_beat || fly_beat) begin
            src_q    <= step(src_q, src_mode_in);
            rd_cnt_q <= rd_cnt_q + COUNT_ONE;
         end
         if (fifo_pop || fly_beat) begin
            dst_q    <= step(dst_q, dst_mode_in);
            wr_cnt_q <= wr_cnt_q + COUNT_ONE;
         end
      end
   end

   // ------------------------------------------------------------------
   // data register and masked compare
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         data_reg_q <= DATA_RST;
         load_q     <= 1'b0;
         match_q    <= 1'b0;
      end else if (state_q == ST_IDLE) begin
         load_q  <= 1'b0;
         match_q <= 1'b0;
      end else begin
         // compare the registered byte a cycle later, off the bus timing path
         load_q <= rd_beat || fly_beat;
         if (rd_beat || fly_beat) begin
            data_reg_q <= data_in;
         end
         // mask bit set means ignore that bit
         if (load_q && op_in != OP_TRANSFER &&
             ((data_reg_q ^ match_byte_in) & ~match_mask_in) == DATA_RST) begin
            match_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         done_q <= 1'b0;
      end else begin
         done_q <= (state_d == ST_DONE);
      end
   end

   // ------------------------------------------------------------------
   // bus outputs
   // ------------------------------------------------------------------
   logic owns_bus;
   assign owns_bus = grant_s2_q &&
                     (state_q == ST_READ || state_q == ST_WRITE || state_q == ST_FLY);

   // request drops in the cycle done rises, so the bus is handed back with the notify
   assign bus_req_out = (state_q == ST_REQ) || owns_bus;
   assign done_out    = done_q;
   assign match_out   = match_q;
   assign busy_out    = (state_q != ST_IDLE) && (state_q != ST_DONE);
   assign count_out   = wr_cnt_q;
   assign addr_oe_out = owns_bus;
   always_comb begin
      addr_out = src_q;
      if (state_q == ST_WRITE) begin
         addr_out = dst_q;
      end else if (state_q == ST_FLY) begin
         addr_out = src_is_mem ? src_q : dst_q;
      end
   end
   assign mem_rd_out  = owns_bus && ((rd_beat && src_is_mem) || (fly_beat && src_is_mem));
   assign io_rd_out   = owns_bus && ((rd_beat && !src_is_mem) || (fly_beat && !src_is_mem));
   assign mem_wr_out  = owns_bus && ((fifo_pop && dst_is_mem) || (fly_beat && dst_is_mem));
   assign io_wr_out   = owns_bus && ((fifo_pop && !dst_is_mem) || (fly_beat && !dst_is_mem));
   assign data_out    = fifo_out_data;
   assign data_oe_out = owns_bus && (state_q == ST_WRITE) && fifo_out_valid;

   // ------------------------------------------------------------------
   // read-to-write buffer
   // ------------------------------------------------------------------
   byte_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (FIFO_D)
   ) u_fifo (
      .clk_in        (clk_in),
      .sys_rst_in    (sys_rst_in),
      .in_valid_in   (fifo_push),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (data_in),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (fifo_pop),
      .out_data_out  (fifo_out_data),
      .flush_in      (fifo_flush)
   );
endmodule

// ### tb/dma_channel_asserts.sv
// Purpose: port-level checks of the transfer/search engine
// Assumes: one clock, synchronous active-high reset
// Notes:   ready is allowed 1 to 4 cycles of latency through its synchroniser
`timescale 1ns/1ps
module dma_channel_asserts (
   // clock and reset
   input wire logic                        clk_in,
   input wire logic                        sys_rst_in,
   // programming
   input wire logic                        enable_in,
   input wire dma_pkg::dir_t               dir_in,
   input wire dma_pkg::op_class_t          op_in,
   input wire logic                        flyby_in,
   input wire dma_pkg::addr_mode_t         src_mode_in,
   input wire logic [dma_pkg::LEN_W-1:0]   block_len_in,
   // handshake and bus
   input wire logic                        periph_ready_in,
   input wire logic                        bus_req_out,
   input wire logic                        done_out,
   input wire logic                        match_out,
   input wire logic [dma_pkg::LEN_W-1:0]   count_out,
   input wire logic [dma_pkg::ADDR_W-1:0]  addr_out,
   input wire logic                        addr_oe_out,
   input wire logic                        mem_rd_out,
   input wire logic                        mem_wr_out,
   input wire logic                        io_rd_out,
   input wire logic                        io_wr_out
);
   import dma_pkg::*;
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   wire rd_s  = mem_rd_out | io_rd_out;
   wire wr_s  = mem_wr_out | io_wr_out;
   wire fly_s = flyby_in && dir_in != DIR_MEM_MEM && op_in != OP_SEARCH;
   function automatic logic [15:0] step(addr_mode_t m, logic [15:0] a);
      return (m == ADDR_INC) ? a + 16'h0001 : (m == ADDR_DEC) ? a - 16'h0001 : a;
   endfunction
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   chk_strobe_owns_bus: assert property ((rd_s || wr_s) |-> addr_oe_out && bus_req_out)
      else $error("strobe without bus ownership");
   chk_ready_gate: assert property ((rd_s || wr_s) |-> enable_in &&
      ($past(periph_ready_in, 1) || $past(periph_ready_in, 2) ||
       $past(periph_ready_in, 3) || $past(periph_ready_in, 4)))
      else $error("strobe while disabled or not ready");
   chk_seq_split: assert property ((!fly_s && rd_s) |-> !wr_s)
      else $error("sequential read and write in one cycle");
   chk_flyby_pair: assert property ((fly_s && (rd_s || wr_s)) |->
      (dir_in == DIR_MEM_IO ? (mem_rd_out && io_wr_out) : (io_rd_out && mem_wr_out)))
      else $error("flyby strobes not paired");
   chk_search_nowrite: assert property ((op_in == OP_SEARCH) |-> !wr_s)
      else $error("write strobe during search only");
   chk_count_bound: assert property (enable_in |-> count_out <= block_len_in)
      else $error("byte count beyond block length");
   chk_count_step: assert property ((enable_in && $past(enable_in) &&
      count_out != $past(count_out)) |->
      (count_out == $past(count_out) + 16'h0001 || count_out == COUNT_RST))
      else $error("byte count jumped");
   chk_done_release: assert property (done_out |-> !bus_req_out && !addr_oe_out && !rd_s)
      else $error("bus still held after done");
   chk_done_count: assert property ((done_out && op_in != OP_SEARCH) |->
      count_out == block_len_in)
      else $error("done before full block");
   chk_addr_step: assert property ((rd_s && $past(rd_s) && !fly_s && !wr_s &&
      !$past(wr_s)) |-> addr_out == step(src_mode_in, $past(addr_out)))
      else $error("source address stepped wrongly");
   cover property (fly_s && rd_s);
   cover property ($rose(done_out));
   cover property ($rose(match_out));
endmodule

// ### tb/bus_host_model.sv
// Purpose: host, memory and peripheral seen from the engine's bus side
// Assumes: grant follows a request one cycle later and falls one cycle after it
// Notes:   memory byte is a fixed function of the address, no storage
`timescale 1ns/1ps
module bus_host_model (
   // clock and reset
   input  wire logic                        clk_in,
   input  wire logic                        sys_rst_in,
   // engine side
   input  wire logic                        bus_req_in,
   input  wire logic                        stall_in,
   input  wire logic                        rd_in,
   input  wire logic [dma_pkg::ADDR_W-1:0]  addr_in,
   output logic                             bus_grant_out,
   output logic                             periph_ready_out,
   output logic      [dma_pkg::DATA_W-1:0]  data_out
);
   import dma_pkg::*;
   logic [DATA_W-1:0] last_q;
   // host floats its drivers and grants only a standing request
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         bus_grant_out <= 1'b0;
      end else begin
         bus_grant_out <= bus_req_in;
      end
   end
   // released data shows the inverse of the last byte, so stale reads show up
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         last_q <= DATA_RST;
      end else if (rd_in) begin
         last_q <= data_out;
      end
   end
   assign periph_ready_out = !stall_in;
   assign data_out = rd_in ? (addr_in[7:0] ^ addr_in[15:8] ^ 8'h5a) : ~last_q;
endmodule

// ### tb/test_single_channel_dma_transfer_search.sv
// Purpose: randomised block transfers and searches through the engine
// Assumes: host model grants promptly, peripheral ready stalls at random
// Notes:   flyby bytes bypass the engine, so their data and match are not checked
`timescale 1ns/1ps
module test_single_channel_dma_transfer_search;
   import dma_pkg::*;
   logic        clk_in = 1'b0, sys_rst_in = 1'b1, enable_in = 1'b0, flyby_in = 1'b0;
   dir_t        dir_in = DIR_MEM_MEM;
   op_class_t   op_in = OP_TRANSFER;
   addr_mode_t  src_mode_in = ADDR_INC, dst_mode_in = ADDR_INC;
   logic [15:0] src_addr_in = 16'h0000, dst_addr_in = 16'h0000, block_len_in = 16'h0000;
   logic [7:0]  match_byte_in = 8'h00, match_mask_in = 8'h00, data_in, data_out;
   logic        periph_ready_in, bus_grant_in, bus_req_out, done_out, match_out, busy_out;
   logic        addr_oe_out, mem_rd_out, mem_wr_out, io_rd_out, io_wr_out, data_oe_out;
   logic        stall = 1'b0, fly = 1'b0, mexp;
   logic [15:0] count_out, addr_out, sa, da;
   logic [7:0]  q[$];
   int          nrd, nwr, miscompares = 0, checked = 0;
   // ---------------------------------------------------------------
   // design, far side and helpers
   // ---------------------------------------------------------------
   dma_channel DUT (.clk_in, .sys_rst_in, .enable_in, .dir_in, .op_in, .flyby_in,
      .src_addr_in, .dst_addr_in, .src_mode_in, .dst_mode_in, .block_len_in,
      .match_byte_in, .match_mask_in, .periph_ready_in, .bus_grant_in, .bus_req_out,
      .done_out, .match_out, .busy_out, .count_out, .addr_out, .addr_oe_out, .mem_rd_out,
      .mem_wr_out, .io_rd_out, .io_wr_out, .data_in, .data_out, .data_oe_out);
   bus_host_model HOST (.clk_in, .sys_rst_in, .bus_req_in(bus_req_out), .stall_in(stall),
      .rd_in(mem_rd_out | io_rd_out), .addr_in(addr_out), .bus_grant_out(bus_grant_in),
      .periph_ready_out(periph_ready_in), .data_out(data_in));
   always #25 clk_in = ~clk_in;
   always @(posedge clk_in) stall <= ($urandom % 6) == 0;
   function automatic logic [7:0] fn(logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5a;
   endfunction
   function automatic logic [15:0] nxt(logic [15:0] a, addr_mode_t m);
      return (m == ADDR_INC) ? a + 16'h0001 : (m == ADDR_DEC) ? a - 16'h0001 : a;
   endfunction
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (miscompares == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // bus monitor: expected addresses and bytes in order
   // ---------------------------------------------------------------
   always @(posedge clk_in) begin
      if (!sys_rst_in && (mem_rd_out | io_rd_out | mem_wr_out | io_wr_out)) begin
         if (fly) begin
            cmp(addr_out, (dir_in == DIR_MEM_IO) ? sa : da);
            sa = nxt(sa, src_mode_in);
            da = nxt(da, dst_mode_in);
            nrd++;
            nwr++;
         end else if (mem_rd_out | io_rd_out) begin
            cmp(addr_out, sa);
            cmp({15'h0, io_rd_out}, {15'h0, dir_in == DIR_IO_MEM});
            cmp({15'h0, busy_out}, 16'h0001);
            q.push_back(fn(sa));
            if (op_in != OP_TRANSFER) begin
               mexp = mexp | (((fn(sa) ^ match_byte_in) & ~match_mask_in) == 8'h00);
            end
            sa = nxt(sa, src_mode_in);
            nrd++;
         end else begin
            cmp(addr_out, da);
            cmp({8'h0, data_out}, {8'h0, q.pop_front()});
            cmp({15'h0, io_wr_out}, {15'h0, dir_in == DIR_MEM_IO});
            cmp({15'h0, data_oe_out}, 16'h0001);
            da = nxt(da, dst_mode_in);
            nwr++;
         end
      end
   end
   // one block per call; 20 bytes forces a second FIFO fill
   task automatic run(input int i);
      int          k;
      logic [15:0] len;
      len = (i == 0) ? 16'h0001 : (i == 1) ? 16'h0014 : 16'(1 + $urandom % 40);
      @(posedge clk_in);
      dir_in <= dir_t'(i % 3);
      op_in <= op_class_t'((i < 9) ? i / 3 : 0);
      flyby_in <= (i >= 9);
      src_mode_in <= addr_mode_t'($urandom % 3);
      dst_mode_in <= addr_mode_t'($urandom % 3);
      src_addr_in <= 16'($urandom);
      dst_addr_in <= 16'($urandom);
      block_len_in <= len;
      match_byte_in <= 8'($urandom);
      match_mask_in <= (i % 2) ? 8'hff : 8'($urandom);
      @(posedge clk_in);
      sa = src_addr_in;
      da = dst_addr_in;
      fly = flyby_in && dir_in != DIR_MEM_MEM && op_in != OP_SEARCH;
      nrd = 0;
      nwr = 0;
      mexp = 1'b0;
      q.delete();
      enable_in <= 1'b1;
      for (k = 0; k < 3000 && done_out !== 1'b1; k++) @(posedge clk_in);
      cmp({15'h0, done_out}, 16'h0001);
      cmp(16'(nrd), len);
      cmp({15'h0, busy_out}, 16'h0000);
      cmp(16'(nwr), (op_in == OP_SEARCH) ? 16'h0000 : len);
      if (op_in != OP_SEARCH) cmp(count_out, len);
      if (!fly) cmp({15'h0, match_out}, {15'h0, mexp});
      enable_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      cmp({15'h0, done_out}, 16'h0000);
   endtask
   initial begin
      void'($urandom(85));
      repeat (16) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_in);
      enable_in <= 1'b1;
      repeat (8) @(posedge clk_in);
      cmp({15'h0, bus_req_out}, 16'h0000);
      enable_in <= 1'b0;
      for (int i = 0; i < 12; i++) run(i);
      summarize();
   end
   initial begin
      #2500000;
      miscompares++;
      summarize();
   end
endmodule
bind dma_channel dma_channel_asserts CHK (.clk_in, .sys_rst_in, .enable_in, .dir_in, .op_in,
   .flyby_in, .src_mode_in, .block_len_in, .periph_ready_in, .bus_req_out, .done_out,
   .match_out, .count_out, .addr_out, .addr_oe_out, .mem_rd_out, .mem_wr_out, .io_rd_out,
   .io_wr_out);
